// ==== pkg/pmbus_cmd_pkg.sv ====
package pmbus_cmd_pkg;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_OPERATION      = 8'h01;
    localparam logic [7:0] CMD_ON_OFF_CONFIG  = 8'h02;
    localparam logic [7:0] CMD_FAULT_CLEAR    = 8'h03;
    localparam logic [7:0] CMD_CHANNEL_SEL    = 8'h04;
    localparam logic [7:0] CMD_WRITE_LOCK     = 8'h10;
    localparam logic [7:0] CMD_STORE_USER_ALL = 8'h15;
    localparam logic [7:0] CMD_VOUT_DEFAULT   = 8'h21;

    // ------------------------------------------------------------
    // channel selector values
    // ------------------------------------------------------------
    localparam logic [7:0] SEL_ALL          = 8'hFF;
    localparam logic [7:0] SEL_RESET        = 8'hFF;
    localparam logic [7:0] SEL_MAX_PHASE    = 8'h03;
    localparam logic [7:0] CONTROLLER_PHASE = 8'h00;

    // ------------------------------------------------------------
    // write lock levels
    // ------------------------------------------------------------
    localparam logic [7:0] WL_OPEN   = 8'h00;
    localparam logic [7:0] WL_CTRL   = 8'h20;
    localparam logic [7:0] WL_OPER   = 8'h40;
    localparam logic [7:0] WL_STORE  = 8'h80;
    localparam logic [7:0] WL_RESET  = 8'h00;

    // ------------------------------------------------------------
    // status vector layout: [1:0] command errors, above them faults
    // ------------------------------------------------------------
    localparam int         STAT_BAD_DATA_BIT = 0;
    localparam int         STAT_BAD_CMD_BIT  = 1;
    localparam int         STAT_FAULT_LSB    = 2;
    localparam int         NUM_FAULT_DEFAULT = 6;

    localparam logic [7:0] RSP_IDLE          = 8'h00;

endpackage

// ==== verilog/write_gate.sv ====
`timescale 1ns/1ps
module write_gate
    import pmbus_cmd_pkg::*;
#(
    parameter logic [7:0] VOUT_CMD_CODE = CMD_VOUT_DEFAULT
)(
    input  wire logic [7:0] lockLevel,
    input  wire logic [7:0] cmdCode,
    output logic            allowed
);

    // a vout code that aliases a locally handled command would be decoded twice
    if ((VOUT_CMD_CODE == CMD_FAULT_CLEAR) || (VOUT_CMD_CODE == CMD_CHANNEL_SEL)
        || (VOUT_CMD_CODE == CMD_WRITE_LOCK))
    begin : g_chk
        $error("VOUT_CMD_CODE collides with a locally handled command");
    end

    // ------------------------------------------------------------
    // lock level decode
    // ------------------------------------------------------------
    function automatic logic lockPermits(input logic [7:0] lvl, input logic [7:0] code);
        logic ok;
        ok = 1'b0;
        case (lvl)
            WL_OPEN:  ok = 1'b1;
            WL_CTRL:  ok = (code == CMD_WRITE_LOCK) || (code == CMD_OPERATION)
                        || (code == CMD_ON_OFF_CONFIG) || (code == CMD_STORE_USER_ALL)
                        || (code == VOUT_CMD_CODE);
            WL_OPER:  ok = (code == CMD_WRITE_LOCK) || (code == CMD_OPERATION)
                        || (code == CMD_STORE_USER_ALL);
            WL_STORE: ok = (code == CMD_WRITE_LOCK) || (code == CMD_STORE_USER_ALL);
            // unknown level cannot be stored, but fail closed anyway
            default:  ok = (code == CMD_WRITE_LOCK);
        endcase
        return ok;
    endfunction

    always_comb
    begin
        allowed = lockPermits(lockLevel, cmdCode);
    end

endmodule

// ==== verilog/alert_tracker.sv ====
`timescale 1ns/1ps
module alert_tracker
#(
    parameter int NUM_SRC = 8
)(
    input  wire logic               ref_clk,
    input  wire logic               arst_n,
    input  wire logic [NUM_SRC-1:0] srcActive,
    input  wire logic               clearAll,
    input  wire logic               araAck,
    input  wire logic               offOnToggle,
    output logic [NUM_SRC-1:0]      flags,
    output logic                    alertOeN
);

    typedef struct packed {
        logic [NUM_SRC-1:0] flags;
        logic [NUM_SRC-1:0] seen;
        logic [NUM_SRC-1:0] blocked;
        logic               alert;
    } alert_state_t;

    alert_state_t s_q;
    alert_state_t s_d;
    logic [NUM_SRC-1:0] newSet;
    logic               trigger;

    if (NUM_SRC < 1)
    begin : g_chk
        $error("alert_tracker needs at least one source");
    end

    always_comb
    begin
        s_d = s_q;
        // set wins over clear; a persisting source lands straight back in
        s_d.flags = (clearAll ? '0 : s_q.flags) | srcActive;
        newSet    = srcActive & (~s_q.flags | {NUM_SRC{clearAll}});
        if (clearAll || offOnToggle)
        begin
            s_d.blocked = '0;
        end
        else if (araAck)
        begin
            // everything seen while the alert was pending stays mute
            s_d.blocked = s_q.blocked | s_q.seen | s_q.flags | srcActive;
        end
        trigger = |(newSet & ~s_d.blocked);
        if (s_q.alert && !araAck)
        begin
            s_d.seen = s_q.seen | s_q.flags | srcActive;
        end
        else
        begin
            s_d.seen = '0;
        end
        if (clearAll)
        begin
            s_d.alert = trigger;
        end
        else if (araAck)
        begin
            s_d.alert = 1'b0;
        end
        else
        begin
            s_d.alert = s_q.alert | trigger;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign flags    = s_q.flags;
    assign alertOeN = ~s_q.alert;

endmodule

// ==== verilog/pmbus_fault_phase_protect.sv ====
`timescale 1ns/1ps
module pmbus_fault_phase_protect
    import pmbus_cmd_pkg::*;
#(
    parameter int         NUM_FAULT     = NUM_FAULT_DEFAULT,
    parameter logic [7:0] VOUT_CMD_CODE = CMD_VOUT_DEFAULT
)(
    input  wire logic                 ref_clk,
    input  wire logic                 arst_n,
    input  wire logic                 cmdValid,
    input  wire logic [7:0]           cmdCode,
    input  wire logic                 cmdWrite,
    input  wire logic                 cmdHasData,
    input  wire logic [7:0]           cmdData,
    input  wire logic                 araAck,
    input  wire logic                 offOnToggle,
    input  wire logic [NUM_FAULT-1:0] faultSrc,
    input  wire logic                 followerStrapPin,
    input  wire logic [1:0]           phasePositionConfig,
    input  wire logic [2:0]           phaseCount,
    output logic                      rspValid,
    output logic [7:0]                rspData,
    output logic                      fwdValid,
    output logic                      fwdWrite,
    output logic [7:0]                fwdCode,
    output logic [7:0]                fwdData,
    output logic [7:0]                channelSel,
    output logic [7:0]                writeLockLevel,
    output logic [7:0]                ownPhase,
    output logic                      clearPulse,
    output logic                      rejectCmd,
    output logic                      rejectData,
    output logic [NUM_FAULT+1:0]      statusFlags,
    output logic                      alertOut,
    output logic                      alertOeN
);
    import pmbus_cmd_pkg::*;

    localparam int NUM_SRC = NUM_FAULT + STAT_FAULT_LSB;

    if (NUM_FAULT < 1)
    begin : g_chk
        $error("NUM_FAULT must be at least one");
    end

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic selValid(input logic [7:0] v, input logic [2:0] cnt);
        return (v == SEL_ALL) || ((v <= SEL_MAX_PHASE) && (v < {5'h00, cnt}));
    endfunction

    function automatic logic lockValid(input logic [7:0] v);
        return (v == WL_OPEN) || (v == WL_CTRL) || (v == WL_OPER) || (v == WL_STORE);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] lock;
        logic [7:0] own;
        logic       strapDone;
        logic       rspValid;
        logic [7:0] rspData;
        logic       fwdValid;
        logic       fwdWrite;
        logic [7:0] fwdCode;
        logic [7:0] fwdData;
        logic       clearPulse;
        logic       rejectCmd;
        logic       rejectData;
    } top_state_t;

    top_state_t         s_q;
    top_state_t         s_d;
    logic               writeOk;
    logic               addressed;
    logic               isWr;
    logic               isRd;
    logic [NUM_SRC-1:0] srcVec;
    logic [NUM_SRC-1:0] flagVec;
    logic               alertOeNInt;

    write_gate #(
        .VOUT_CMD_CODE (VOUT_CMD_CODE)
    ) u_gate (
        .lockLevel (s_q.lock),
        .cmdCode   (cmdCode),
        .allowed   (writeOk)
    );

    // command errors are flagged and alerted like any fault source
    assign srcVec = {faultSrc, s_q.rejectCmd, s_q.rejectData};

    alert_tracker #(
        .NUM_SRC (NUM_SRC)
    ) u_alert (
        .ref_clk     (ref_clk),
        .arst_n      (arst_n),
        .srcActive   (srcVec),
        .clearAll    (s_q.clearPulse),
        .araAck      (araAck),
        .offOnToggle (offOnToggle),
        .flags       (flagVec),
        .alertOeN    (alertOeNInt)
    );

    assign addressed = (s_q.sel == SEL_ALL) || (s_q.sel == s_q.own);
    assign isWr      = cmdValid && cmdWrite;
    assign isRd      = cmdValid && !cmdWrite;

    // ------------------------------------------------------------
    // command handling
    // ------------------------------------------------------------
    always_comb
    begin
        s_d            = s_q;
        s_d.rspValid   = 1'b0;
        s_d.fwdValid   = 1'b0;
        s_d.clearPulse = 1'b0;
        s_d.rejectCmd  = 1'b0;
        s_d.rejectData = 1'b0;
        // strap taken on the first edge after release, never under reset
        if (!s_q.strapDone)
        begin
            s_d.strapDone = 1'b1;
            s_d.own = followerStrapPin ? {6'h00, phasePositionConfig} : CONTROLLER_PHASE;
        end
        if (cmdValid)
        begin
            case (cmdCode)
                CMD_FAULT_CLEAR:
                begin
                    if (!cmdWrite || cmdHasData)
                    begin
                        s_d.rejectCmd = 1'b1;
                    end
                    else if (!writeOk)
                    begin
                        s_d.rejectCmd = 1'b1;
                    end
                    else
                    begin
                        // flags only: no path to the converter enable
                        s_d.clearPulse = addressed;
                    end
                end
                CMD_CHANNEL_SEL:
                begin
                    if (isRd)
                    begin
                        s_d.rspValid = 1'b1;
                        s_d.rspData  = s_q.sel;
                    end
                    else if (!writeOk || !cmdHasData)
                    begin
                        s_d.rejectCmd = 1'b1;
                    end
                    else if (selValid(cmdData, phaseCount))
                    begin
                        s_d.sel = cmdData;
                    end
                    else
                    begin
                        s_d.rejectData = 1'b1;
                    end
                end
                CMD_WRITE_LOCK:
                begin
                    if (isRd)
                    begin
                        s_d.rspValid = 1'b1;
                        s_d.rspData  = s_q.lock;
                    end
                    else if (!cmdHasData)
                    begin
                        s_d.rejectCmd = 1'b1;
                    end
                    else if (lockValid(cmdData))
                    begin
                        s_d.lock = cmdData;
                    end
                    else
                    begin
                        s_d.rejectData = 1'b1;
                    end
                end
                default:
                begin
                    if (isRd || writeOk)
                    begin
                        s_d.fwdValid = 1'b1;
                        s_d.fwdWrite = cmdWrite;
                        s_d.fwdCode  = cmdCode;
                        s_d.fwdData  = cmdData;
                    end
                    else
                    begin
                        s_d.rejectCmd = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q            <= '0;
            s_q.sel        <= SEL_RESET;
            s_q.lock       <= WL_RESET;
            s_q.own        <= CONTROLLER_PHASE;
            s_q.rspData    <= RSP_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rspValid       = s_q.rspValid;
    assign rspData        = s_q.rspData;
    assign fwdValid       = s_q.fwdValid;
    assign fwdWrite       = s_q.fwdWrite;
    assign fwdCode        = s_q.fwdCode;
    assign fwdData        = s_q.fwdData;
    assign channelSel     = s_q.sel;
    assign writeLockLevel = s_q.lock;
    assign ownPhase       = s_q.own;
    assign clearPulse     = s_q.clearPulse;
    assign rejectCmd      = s_q.rejectCmd;
    assign rejectData     = s_q.rejectData;
    assign statusFlags    = flagVec;
    // open drain: level is always low, only the enable moves
    assign alertOut       = 1'b0;
    assign alertOeN       = alertOeNInt;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_clear_dataless: assert property (@(posedge ref_clk) disable iff (!arst_n)
        cmdValid && (cmdCode == CMD_FAULT_CLEAR) && (!cmdWrite || cmdHasData)
        |=> rejectCmd && !clearPulse && !rspValid)
        else $error("fault clear with data or read was not refused");

    a_clear_target: assert property (@(posedge ref_clk) disable iff (!arst_n)
        isWr && (cmdCode == CMD_FAULT_CLEAR) && !cmdHasData && writeOk
        |=> clearPulse == $past(addressed))
        else $error("fault clear did not follow the channel selector");

    a_clear_wipes: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clearPulse |=> statusFlags == $past(srcVec))
        else $error("status flags not wiped to the live sources");

    a_clear_release: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clearPulse && (srcVec == '0) |=> alertOeN && (statusFlags == '0))
        else $error("alert not released by fault clear");

    a_ara_release: assert property (@(posedge ref_clk) disable iff (!arst_n)
        araAck && !clearPulse
        |=> alertOeN && (statusFlags == ($past(statusFlags) | $past(srcVec))))
        else $error("alert response must release alert and keep flags");

    a_sel_reject: assert property (@(posedge ref_clk) disable iff (!arst_n)
        isWr && cmdHasData && (cmdCode == CMD_CHANNEL_SEL) && writeOk
        && !selValid(cmdData, phaseCount)
        |=> rejectData && $stable(channelSel) ##1 statusFlags[STAT_BAD_DATA_BIT])
        else $error("unsupported selector value accepted");

    a_lock_reject: assert property (@(posedge ref_clk) disable iff (!arst_n)
        isWr && cmdHasData && (cmdCode == CMD_WRITE_LOCK) && !lockValid(cmdData)
        |=> rejectData && (writeLockLevel == $past(writeLockLevel)))
        else $error("invalid lock level accepted");

    a_blocked_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
        isWr && !writeOk && (cmdCode != CMD_WRITE_LOCK)
        |=> rejectCmd && !fwdValid && $stable(channelSel)
        ##1 statusFlags[STAT_BAD_CMD_BIT])
        else $error("write passed a lock that forbids it");

    a_read_passes: assert property (@(posedge ref_clk) disable iff (!arst_n)
        isRd && (cmdCode != CMD_FAULT_CLEAR)
        |=> (fwdValid || rspValid) && !rejectCmd)
        else $error("read refused");

    a_lock_levels: assert property (@(posedge ref_clk) disable iff (!arst_n)
        lockValid(writeLockLevel) && (writeLockLevel != WL_OPEN) && isWr
        && (cmdCode == CMD_STORE_USER_ALL)
        |=> fwdValid && (fwdCode == CMD_STORE_USER_ALL))
        else $error("store command blocked by a lock level");

endmodule

// ==== tb/pmbus_host_model.sv ====
`timescale 1ns/1ps
module pmbus_host_model (
    input  wire logic ref_clk,
    output logic      cmdValid,
    output logic [7:0] cmdCode,
    output logic      cmdWrite,
    output logic      cmdHasData,
    output logic [7:0] cmdData,
    output logic      araAck,
    output logic      offOnToggle
);
    // ------------------------------------------------------------
    // transaction driver
    // ------------------------------------------------------------
    initial
    begin
        cmdValid    = 1'b0;
        cmdCode     = 8'h00;
        cmdWrite    = 1'b0;
        cmdHasData  = 1'b0;
        cmdData     = 8'h00;
        araAck      = 1'b0;
        offOnToggle = 1'b0;
    end

    // released lines show the inverse so stale values never match
    task automatic issue(input logic [7:0] code, input logic wr, input logic hd,
                         input logic [7:0] data);
        @(posedge ref_clk);
        #1;
        cmdValid   = 1'b1;
        cmdCode    = code;
        cmdWrite   = wr;
        cmdHasData = hd;
        cmdData    = data;
        @(posedge ref_clk);
        #1;
        cmdValid   = 1'b0;
        cmdCode    = ~code;
        cmdWrite   = ~wr;
        cmdHasData = ~hd;
        cmdData    = ~data;
    endtask

    task automatic pulse(input logic ara);
        @(posedge ref_clk);
        #1;
        if (ara)
            araAck = 1'b1;
        else
            offOnToggle = 1'b1;
        @(posedge ref_clk);
        #1;
        araAck      = 1'b0;
        offOnToggle = 1'b0;
    endtask
endmodule

// ==== tb/test_pmbus_fault_phase_protect.sv ====
`timescale 1ns/1ps
module test_pmbus_fault_phase_protect;
    import pmbus_cmd_pkg::*;
    logic       ref_clk, arst_n, cmdValid, cmdWrite, cmdHasData, araAck, offOnToggle;
    logic [7:0] cmdCode, cmdData, rspData, fwdCode, fwdData, channelSel, writeLockLevel;
    logic [7:0] ownPhase, statusFlags;
    logic [5:0] faultSrc;
    logic [1:0] phasePositionConfig;
    logic [2:0] phaseCount;
    logic       followerStrapPin, rspValid, fwdValid, fwdWrite, clearPulse;
    logic       rejectCmd, rejectData, alertOut, alertOeN;
    int         failCount, numChecks;
    logic [7:0] lv [4] = '{WL_OPEN, WL_CTRL, WL_OPER, WL_STORE};
    logic [7:0] cd [5] = '{CMD_OPERATION, CMD_ON_OFF_CONFIG, CMD_STORE_USER_ALL,
                           CMD_VOUT_DEFAULT, 8'h30};
    logic [4:0] okv [4] = '{5'b11111, 5'b01111, 5'b00101, 5'b00100};

    pmbus_host_model i_host (.ref_clk(ref_clk), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdWrite(cmdWrite), .cmdHasData(cmdHasData), .cmdData(cmdData),
        .araAck(araAck), .offOnToggle(offOnToggle));

    pmbus_fault_phase_protect i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdWrite(cmdWrite),
        .cmdHasData(cmdHasData), .cmdData(cmdData), .araAck(araAck),
        .offOnToggle(offOnToggle), .faultSrc(faultSrc), .followerStrapPin(followerStrapPin),
        .phasePositionConfig(phasePositionConfig), .phaseCount(phaseCount),
        .rspValid(rspValid), .rspData(rspData), .fwdValid(fwdValid), .fwdWrite(fwdWrite),
        .fwdCode(fwdCode), .fwdData(fwdData), .channelSel(channelSel),
        .writeLockLevel(writeLockLevel), .ownPhase(ownPhase), .clearPulse(clearPulse),
        .rejectCmd(rejectCmd), .rejectData(rejectData), .statusFlags(statusFlags),
        .alertOut(alertOut), .alertOeN(alertOeN));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic closeOut();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        numChecks++;
        if (got !== exp)
        begin
            failCount++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask

    // pulses sampled in the one cycle they stand: {rsp, fwd, clear, badCmd, badData}
    task automatic cmdx(input logic [7:0] code, input logic wr, input logic hd,
                        input logic [7:0] data, input logic [4:0] exp);
        i_host.issue(code, wr, hd, data);
        check("pulses", {3'h0, exp},
              {3'h0, rspValid, fwdValid, clearPulse, rejectCmd, rejectData});
    endtask

    task automatic rst(input logic fol, input logic [1:0] pos);
        arst_n = 1'b0;
        followerStrapPin = fol;
        phasePositionConfig = pos;
        repeat (10) @(posedge ref_clk);
        #1;
        arst_n = 1'b1;
        step();
        step();
    endtask

    task automatic wipe();
        cmdx(CMD_FAULT_CLEAR, 1'b1, 1'b0, 8'h00, 5'b00100);
        step();
        check("flags", 8'h00, statusFlags);
        check("alert", 8'h01, {7'h0, alertOeN});
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        failCount++;
        closeOut();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        failCount = 0;
        numChecks = 0;
        faultSrc = 6'h00;
        phaseCount = 3'd4;
        rst(1'b0, 2'd0);
        check("sel", SEL_RESET, channelSel);
        check("lock", WL_RESET, writeLockLevel);
        check("alert", 8'h01, {7'h0, alertOeN});
        check("phase", CONTROLLER_PHASE, ownPhase);
        check("alertout", 8'h00, {7'h0, alertOut});
        cmdx(CMD_CHANNEL_SEL, 1'b0, 1'b0, 8'h00, 5'b10000);
        check("selread", SEL_ALL, rspData);
        for (int v = 0; v < 4; v++)
        begin
            cmdx(CMD_CHANNEL_SEL, 1'b1, 1'b1, 8'(v), 5'b00000);
            check("sel", 8'(v), channelSel);
        end
        cmdx(CMD_CHANNEL_SEL, 1'b1, 1'b1, 8'h04, 5'b00001);
        phaseCount = 3'd2;
        cmdx(CMD_CHANNEL_SEL, 1'b1, 1'b1, 8'h02, 5'b00001);
        check("sel", 8'h03, channelSel);
        cmdx(CMD_CHANNEL_SEL, 1'b1, 1'b0, 8'h00, 5'b00010);
        step();
        check("flags", 8'h03, statusFlags);
        check("alert", 8'h00, {7'h0, alertOeN});
        cmdx(CMD_CHANNEL_SEL, 1'b1, 1'b1, SEL_ALL, 5'b00000);
        wipe();
        cmdx(CMD_FAULT_CLEAR, 1'b1, 1'b1, 8'h5A, 5'b00010);
        cmdx(CMD_FAULT_CLEAR, 1'b0, 1'b0, 8'h00, 5'b00010);
        wipe();
        // lock levels against every write class
        for (int i = 0; i < 4; i++)
        begin
            cmdx(CMD_WRITE_LOCK, 1'b1, 1'b1, lv[i], 5'b00000);
            check("lock", lv[i], writeLockLevel);
            for (int j = 0; j < 5; j++)
            begin
                cmdx(cd[j], 1'b1, cd[j] != CMD_STORE_USER_ALL, 8'h5A,
                     okv[i][j] ? 5'b01000 : 5'b00010);
                if (okv[i][j])
                begin
                    check("fwdcode", cd[j], fwdCode);
                    check("fwddata", 8'h5A, fwdData);
                    check("fwdwrite", 8'h01, {7'h0, fwdWrite});
                end
            end
        end
        cmdx(CMD_OPERATION, 1'b0, 1'b0, 8'h00, 5'b01000);
        check("fwdwrite", 8'h00, {7'h0, fwdWrite});
        check("fwdcode", CMD_OPERATION, fwdCode);
        cmdx(CMD_WRITE_LOCK, 1'b0, 1'b0, 8'h00, 5'b10000);
        check("lockread", WL_STORE, rspData);
        cmdx(CMD_CHANNEL_SEL, 1'b1, 1'b1, 8'h00, 5'b00010);
        check("sel", SEL_ALL, channelSel);
        cmdx(CMD_WRITE_LOCK, 1'b1, 1'b1, 8'h55, 5'b00001);
        check("lock", WL_STORE, writeLockLevel);
        step();
        check("flags", 8'h03, statusFlags);
        cmdx(CMD_WRITE_LOCK, 1'b1, 1'b1, WL_OPEN, 5'b00000);
        wipe();
        // persistent fault, alert response, muting
        faultSrc = 6'h01;
        step();
        step();
        check("flags", 8'h04, statusFlags);
        check("alert", 8'h00, {7'h0, alertOeN});
        cmdx(CMD_FAULT_CLEAR, 1'b1, 1'b0, 8'h00, 5'b00100);
        step();
        check("flags", 8'h04, statusFlags);
        check("alert", 8'h00, {7'h0, alertOeN});
        i_host.pulse(1'b1);
        step();
        check("alert", 8'h01, {7'h0, alertOeN});
        check("flags", 8'h04, statusFlags);
        faultSrc = 6'h00;
        step();
        faultSrc = 6'h01;
        step();
        step();
        check("alert", 8'h01, {7'h0, alertOeN});
        faultSrc = 6'h03;
        step();
        step();
        check("flags", 8'h0C, statusFlags);
        check("alert", 8'h00, {7'h0, alertOeN});
        i_host.pulse(1'b0);
        faultSrc = 6'h00;
        wipe();
        // clear addressed to another phase does nothing
        cmdx(CMD_CHANNEL_SEL, 1'b1, 1'b1, 8'h01, 5'b00000);
        faultSrc = 6'h01;
        step();
        step();
        faultSrc = 6'h00;
        cmdx(CMD_FAULT_CLEAR, 1'b1, 1'b0, 8'h00, 5'b00000);
        step();
        check("flags", 8'h04, statusFlags);
        cmdx(CMD_CHANNEL_SEL, 1'b1, 1'b1, 8'h00, 5'b00000);
        wipe();
        // follower strap after a second reset
        rst(1'b1, 2'd2);
        check("phase", 8'h02, ownPhase);
        check("sel", SEL_RESET, channelSel);
        phaseCount = 3'd4;
        cmdx(CMD_CHANNEL_SEL, 1'b1, 1'b1, 8'h02, 5'b00000);
        faultSrc = 6'h20;
        step();
        step();
        faultSrc = 6'h00;
        wipe();
        closeOut();
    end
endmodule
